// ---- sdc_supervisor.sv ----
// Purpose: Enable, start and stop supervision of a servo drive power stage.
// Assumes: Inputs are synchronous to sys_clk; rst_n low stands for power off.
// Notes:   Input levels high mean on; forced stop and limits stop when low.
`timescale 1ns/1ps

// Behaviour
// - After power-up, display shows link-wait letter followed by station number.
// - Absolute detection with lost data raises alarm at power-up; servo-on refused.
// - That alarm clears only by power cycle; servo-on then becomes possible.
// - Enable off shuts base drive; motor coasts without dynamic brake.
// - Any alarm shuts base drive and engages the dynamic brake.
// - Forced stop off shuts base drive, brakes, raises forced-stop warning.
// - Limit off clears droop (lock method) or requests decel stop, stops, holds position; opposite direction allowed.
// - Forced stop released and enable on gives servo-on and ready output.
// - Target selected, a limit on, start rising begins motor rotation.
// - Forced-output test drives output pins directly with control power only.
// - Limit stop method and torque limit delay are selectable settings.
// - Move starts only on start rising edge; ignored while a move runs.
module sdc_supervisor
  import sdc_pkg::*;
#(
  parameter logic [TMR_W-1:0] MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  input  wire logic                main_power_in,
  input  wire logic                link_up_in,
  input  wire logic [STN_W-1:0]    station_no_in,
  input  wire logic                abs_detect_en_in,
  input  wire logic                abs_data_valid_in,
  input  wire logic                alarm_in,
  input  wire logic [DISP_W-1:0]   alarm_code_in,
  input  wire logic                servo_enable_in,
  input  wire logic                motion_start_in,
  input  wire logic                forced_stop_in,
  input  wire logic                fwd_travel_limit_in,
  input  wire logic                rev_travel_limit_in,
  input  wire logic                target_valid_in,
  input  wire logic                move_dir_fwd_in,
  input  wire logic                move_done_in,
  input  wire logic                limit_stop_sel_in,
  input  wire logic [TQ_DLY_W-1:0] torque_dly_ms_in,
  input  wire logic                do_test_in,
  input  wire logic [DO_W-1:0]     do_force_val_in,
  output logic                     base_drive_on,
  output logic                     dyn_brake_on,
  output logic                     servo_lock,
  output logic                     droop_clear,
  output logic                     limit_decel_stop,
  output logic                     ready_out,
  output logic                     move_start,
  output logic                     move_active,
  output logic                     move_dir_fwd,
  output logic                     torque_lim_en,
  output logic                     abs_position_lost_alarm,
  output logic                     forced_stop_warning,
  output logic                     alarm_active,
  output logic [DISP_W-1:0]        disp_code,
  output logic [DO_W-1:0]          do_pins
);

  // ----------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------
  // Converts a station number below one hundred into two BCD digits.
  function automatic logic [7:0] sdc_bcd2(input logic [STN_W-1:0] n);
    logic [STN_W-1:0] tens;
    logic [STN_W-1:0] ones;
    tens = n / STN_TEN;
    ones = n % STN_TEN;
    return {tens[3:0], ones[3:0]};
  endfunction

  sdc_tmr_if tmr_if ();

  sdc_state_t       state_r;
  sdc_state_t       state_nxt;
  logic             init_done_r;
  logic             abs_lost_r;
  logic             start_q_r;
  logic             fwd_q_r;
  logic             rev_q_r;
  logic             ready_r;
  logic             move_start_r;
  logic             move_active_r;
  logic             dir_fwd_r;
  logic             droop_clear_r;
  logic             decel_stop_r;
  logic             torque_en_r;
  logic [DISP_W-1:0] disp_r;
  logic [DO_W-1:0]  do_r;
  logic [DO_W-1:0]  do_normal;
  logic             any_alarm;
  logic             fstop_active;
  logic             start_rise;
  logic             dir_allowed;
  logic             start_ok;
  logic             limit_block;
  logic             limit_fell;
  logic             do_test_mode;

  // ----------------------------------------------------------------------
  // Stop causes.
  // ----------------------------------------------------------------------
  // An alarm is either the latched absolute loss or one raised elsewhere.
  assign any_alarm    = abs_lost_r | alarm_in;
  assign fstop_active = !forced_stop_in;

  // The absolute-loss check is taken once, on the first edge after power-up.
  // Only a fresh reset can clear it, which is how a power cycle recovers.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_done_r <= 1'b0;
      abs_lost_r  <= 1'b0;
    end else if (!init_done_r) begin
      init_done_r <= 1'b1;
      abs_lost_r  <= abs_detect_en_in & !abs_data_valid_in;
    end
  end

  // ----------------------------------------------------------------------
  // Power stage state.
  // ----------------------------------------------------------------------
  // Braking causes are checked first so they win over everything else.
  always_comb begin
    if (any_alarm || fstop_active) begin
      state_nxt = ST_BRAKE;
    end else if (!servo_enable_in || !main_power_in || !init_done_r) begin
      state_nxt = ST_OFF;
    end else begin
      state_nxt = ST_ON;
    end
  end

  // The state register steers the base drive and brake directly.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Ready follows servo-on one cycle after the state settles.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_r == ST_ON);
    end
  end

  // ----------------------------------------------------------------------
  // Travel limits.
  // ----------------------------------------------------------------------
  // Previous limit levels, for detecting the moment a limit opens.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fwd_q_r <= 1'b1;
      rev_q_r <= 1'b1;
    end else begin
      fwd_q_r <= fwd_travel_limit_in;
      rev_q_r <= rev_travel_limit_in;
    end
  end

  assign limit_fell  = (fwd_q_r & !fwd_travel_limit_in) | (rev_q_r & !rev_travel_limit_in);
  // A move heading into an open limit must stop; the other way stays free.
  assign limit_block = move_active_r &&
                       ((dir_fwd_r && !fwd_travel_limit_in) || (!dir_fwd_r && !rev_travel_limit_in));

  // The selected method decides between an immediate droop clear with
  // servo lock and a decelerating stop request, each a one-cycle pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      droop_clear_r <= 1'b0;
      decel_stop_r  <= 1'b0;
    end else begin
      droop_clear_r <= (state_r == ST_ON) && (limit_fell || limit_block) &&
                       (limit_stop_sel_in == LIM_STOP_LOCK);
      decel_stop_r  <= (state_r == ST_ON) && limit_block &&
                       (limit_stop_sel_in == LIM_STOP_DECEL);
    end
  end

  // ----------------------------------------------------------------------
  // Start handling.
  // ----------------------------------------------------------------------
  // Previous start level, for the rising-edge detector.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_q_r <= 1'b0;
    end else begin
      start_q_r <= motion_start_in;
    end
  end

  // A start held high across power-up is not taken as an edge, since the
  // remembered level resets low only while the stage is still off.
  assign start_rise  = motion_start_in & !start_q_r;
  assign dir_allowed = move_dir_fwd_in ? fwd_travel_limit_in : rev_travel_limit_in;
  assign start_ok    = start_rise && (state_r == ST_ON) && target_valid_in &&
                       (fwd_travel_limit_in || rev_travel_limit_in) &&
                       dir_allowed && !move_active_r;

  // One start pulse per accepted edge; a move ends on completion, a limit
  // in its own direction, or the stage leaving servo-on.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_start_r  <= 1'b0;
      move_active_r <= 1'b0;
      dir_fwd_r     <= 1'b0;
    end else begin
      move_start_r <= start_ok;
      if (start_ok) begin
        move_active_r <= 1'b1;
        dir_fwd_r     <= move_dir_fwd_in;
      end else if (move_done_in || limit_block || state_r != ST_ON) begin
        move_active_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Torque limit delay.
  // ----------------------------------------------------------------------
  // Entering servo-on loads the delay; the limit engages once it runs out.
  assign tmr_if.load    = (state_nxt == ST_ON) && (state_r != ST_ON);
  assign tmr_if.load_ms = torque_dly_ms_in;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      torque_en_r <= 1'b0;
    end else begin
      torque_en_r <= (state_r == ST_ON) && tmr_if.expired;
    end
  end

  sdc_ms_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .tmr     (tmr_if.tmr)
  );

  // ----------------------------------------------------------------------
  // Display.
  // ----------------------------------------------------------------------
  // Alarms outrank the forced-stop warning, which outranks link and ready
  // status; status shows a letter followed by the station number.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      disp_r <= DISP_RESET;
    end else if (abs_lost_r) begin
      disp_r <= ALM_ABS_LOST;
    end else if (alarm_in) begin
      disp_r <= alarm_code_in;
    end else if (fstop_active) begin
      disp_r <= WRN_FSTOP;
    end else if (!link_up_in) begin
      disp_r <= {DISP_LINK_WAIT, sdc_bcd2(station_no_in)};
    end else if (state_r == ST_ON) begin
      disp_r <= {DISP_READY, sdc_bcd2(station_no_in)};
    end else begin
      disp_r <= {DISP_NOT_READY, sdc_bcd2(station_no_in)};
    end
  end

  // ----------------------------------------------------------------------
  // Output pins.
  // ----------------------------------------------------------------------
  // Forced output is honoured only while the main supply is off.
  assign do_test_mode = do_test_in && !main_power_in;

  assign do_normal[DO_READY] = ready_r;
  assign do_normal[DO_MOVE]  = move_active_r;
  assign do_normal[DO_ALARM] = any_alarm;
  assign do_normal[DO_WARN]  = fstop_active;

  // Each pin picks either its status bit or its forced value.
  for (genvar i = 0; i < DO_W; i++) begin : g_do
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        do_r[i] <= DO_RESET[i];
      end else begin
        do_r[i] <= do_test_mode ? do_force_val_in[i] : do_normal[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  // Coasting is base drive off with the brake released.
  assign base_drive_on           = (state_r == ST_ON);
  assign dyn_brake_on            = (state_r == ST_BRAKE);
  assign servo_lock              = (state_r == ST_ON) && !move_active_r &&
                                   (!fwd_travel_limit_in || !rev_travel_limit_in);
  assign droop_clear             = droop_clear_r;
  assign limit_decel_stop        = decel_stop_r;
  assign ready_out               = ready_r;
  assign move_start              = move_start_r;
  assign move_active             = move_active_r;
  assign move_dir_fwd            = dir_fwd_r;
  assign torque_lim_en           = torque_en_r;
  assign abs_position_lost_alarm = abs_lost_r;
  assign forced_stop_warning     = fstop_active;
  assign alarm_active            = any_alarm;
  assign disp_code               = disp_r;
  assign do_pins                 = do_r;

endmodule

// ---- sdc_pkg.sv ----
// Purpose: Shared constants and types for the servo start and stop supervisor.
// Assumes: sys_clk runs at 10 MHz; all control inputs are synchronous to it.
// Notes:   Display codes are three hex digits, one per seven-segment position.
package sdc_pkg;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_TIME_NS    = 1000000;
  localparam int unsigned TMR_W         = 16;
  // One millisecond in clock cycles, rounded up as a least time.
  localparam logic [TMR_W-1:0] MS_CYCLES_DEF =
    TMR_W'((MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] TMR_ONE  = 16'h0001;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;

  // ----------------------------------------------------------------------
  // Widths and field positions.
  // ----------------------------------------------------------------------
  localparam int unsigned TQ_DLY_W = 8;
  localparam int unsigned STN_W    = 7;
  localparam int unsigned DISP_W   = 12;
  localparam int unsigned DO_W     = 4;
  localparam int unsigned DO_READY = 0;
  localparam int unsigned DO_MOVE  = 1;
  localparam int unsigned DO_ALARM = 2;
  localparam int unsigned DO_WARN  = 3;
  localparam logic [TQ_DLY_W-1:0] TQ_DLY_ZERO = 8'h00;
  localparam logic [DO_W-1:0]     DO_RESET    = 4'h0;
  localparam logic [STN_W-1:0]    STN_TEN     = 7'h0A;

  // ----------------------------------------------------------------------
  // Display and status codes.
  // ----------------------------------------------------------------------
  localparam logic [3:0]        DISP_LINK_WAIT = 4'hB;
  localparam logic [3:0]        DISP_NOT_READY = 4'hC;
  localparam logic [3:0]        DISP_READY     = 4'hD;
  localparam logic [DISP_W-1:0] ALM_ABS_LOST   = 12'hA25;
  localparam logic [DISP_W-1:0] WRN_FSTOP      = 12'hAE6;
  localparam logic [DISP_W-1:0] DISP_RESET     = 12'hB00;

  // Stop method at the travel limits.
  localparam logic LIM_STOP_LOCK  = 1'b0;
  localparam logic LIM_STOP_DECEL = 1'b1;

  // Drive power-stage state.
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_ON    = 3'b010,
    ST_BRAKE = 3'b100
  } sdc_state_t;

endpackage

// ---- sdc_tmr_if.sv ----
// Purpose: Carrier between the supervisor and its millisecond timer.
// Assumes: One clock domain.
// Notes:   The supervisor loads a delay; the timer reports expiry as a level.
`timescale 1ns/1ps
interface sdc_tmr_if;
  import sdc_pkg::*;
  logic                load;
  logic [TQ_DLY_W-1:0] load_ms;
  logic                ms_tick;
  logic                expired;
  modport ctl (output load, output load_ms, input ms_tick, input expired);
  modport tmr (input load, input load_ms, output ms_tick, output expired);
endinterface

// ---- sdc_ms_timer.sv ----
// Purpose: Millisecond tick source and loadable millisecond down counter.
// Assumes: MS_CYCLES is the number of sys_clk cycles in one millisecond.
// Notes:   Expired reads high once the loaded delay has run out.
`timescale 1ns/1ps
module sdc_ms_timer
  import sdc_pkg::*;
#(
  parameter logic [TMR_W-1:0] MS_CYCLES = MS_CYCLES_DEF
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  sdc_tmr_if.tmr    tmr
);

  logic [TMR_W-1:0]    presc_r;
  logic                tick_r;
  logic [TQ_DLY_W-1:0] ms_left_r;

  // ----------------------------------------------------------------------
  // Prescaler.
  // ----------------------------------------------------------------------
  // A free-running divider yields a one-cycle tick every millisecond.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= TMR_ZERO;
      tick_r  <= 1'b0;
    end else if (presc_r == MS_CYCLES - TMR_ONE) begin
      presc_r <= TMR_ZERO;
      tick_r  <= 1'b1;
    end else begin
      presc_r <= presc_r + TMR_ONE;
      tick_r  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Delay counter.
  // ----------------------------------------------------------------------
  // A load restarts the count; each tick then takes one millisecond off.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_left_r <= TQ_DLY_ZERO;
    end else if (tmr.load) begin
      ms_left_r <= tmr.load_ms;
    end else if (tick_r && ms_left_r != TQ_DLY_ZERO) begin
      ms_left_r <= ms_left_r - TQ_DLY_W'(1);
    end
  end

  assign tmr.ms_tick = tick_r;
  assign tmr.expired = (ms_left_r == TQ_DLY_ZERO) && !tmr.load;

endmodule

// ---- sdc_sup_asserts.sv ----
// Purpose: Port checks on the servo start and stop supervisor.
// Assumes: One clock domain; rst_n low stands for power off.
// Notes:   Bound into sdc_supervisor from tb.
`timescale 1ns/1ps
module sdc_sup_asserts
  import sdc_pkg::*;
(
  input wire logic                sys_clk,
  input wire logic                rst_n,
  input wire logic                motion_start_in,
  input wire logic                forced_stop_in,
  input wire logic                servo_enable_in,
  input wire logic                fwd_travel_limit_in,
  input wire logic                rev_travel_limit_in,
  input wire logic                target_valid_in,
  input wire logic                move_dir_fwd_in,
  input wire logic                main_power_in,
  input wire logic                limit_stop_sel_in,
  input wire logic [TQ_DLY_W-1:0] torque_dly_ms_in,
  input wire logic                do_test_in,
  input wire logic [DO_W-1:0]     do_force_val_in,
  input wire logic                base_drive_on,
  input wire logic                dyn_brake_on,
  input wire logic                droop_clear,
  input wire logic                limit_decel_stop,
  input wire logic                ready_out,
  input wire logic                move_start,
  input wire logic                move_active,
  input wire logic                move_dir_fwd,
  input wire logic                torque_lim_en,
  input wire logic                abs_position_lost_alarm,
  input wire logic                alarm_active,
  input wire logic [DO_W-1:0]     do_pins
);
  // ----------------------------------------------------------------------
  // Sequences and properties.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // A start edge the drive must take.
  sequence start_req;
    $rose(motion_start_in) && base_drive_on && target_valid_in && !move_active &&
      (move_dir_fwd_in ? fwd_travel_limit_in : rev_travel_limit_in);
  endsequence
  // A forward move into an open forward limit.
  sequence fwd_blocked;
    move_active && move_dir_fwd && !fwd_travel_limit_in && base_drive_on;
  endsequence

  a_brake_wins: assert property ((!forced_stop_in || alarm_active) |=> dyn_brake_on && !base_drive_on)
    else $error("no brake");
  a_coast_off: assert property ((!servo_enable_in && forced_stop_in && !alarm_active) |=> !base_drive_on && !dyn_brake_on)
    else $error("no coast");
  a_abs_refuse: assert property (abs_position_lost_alarm |-> !base_drive_on && !ready_out)
    else $error("on while lost");
  a_abs_held: assert property (abs_position_lost_alarm |=> abs_position_lost_alarm)
    else $error("lost alarm cleared");
  a_ready_rise: assert property ($rose(base_drive_on) |-> !ready_out ##1 ready_out)
    else $error("ready late");
  a_start_take: assert property (start_req |=> move_start && move_active)
    else $error("start missed");
  a_start_ignore: assert property (move_active && $rose(motion_start_in) |=> !move_start)
    else $error("start not ignored");
  a_limit_droop: assert property (base_drive_on && !limit_stop_sel_in && $fell(fwd_travel_limit_in) |=> droop_clear)
    else $error("no droop clear");
  a_limit_halt: assert property (fwd_blocked |=> !move_active)
    else $error("move not halted");
  a_limit_decel: assert property (fwd_blocked ##0 limit_stop_sel_in |=> limit_decel_stop)
    else $error("no decel stop");
  a_force_out: assert property (do_test_in && !main_power_in |=> do_pins == $past(do_force_val_in))
    else $error("pins not forced");
  a_torque_zero: assert property ($rose(base_drive_on) && torque_dly_ms_in == TQ_DLY_ZERO |-> ##[1:3] torque_lim_en)
    else $error("torque late");
endmodule

// ---- sdc_host_model.sv ----
// Purpose: Host model driving enable, start, forced stop and limits.
// Assumes: Lines change 1 ns after a rising sys_clk edge.
// Notes:   START_HOLD is the start on-time in cycles (6 ms).
`timescale 1ns/1ps
module sdc_host_model #(
  parameter int START_HOLD = 60
) (
  input  wire logic sys_clk,
  output logic      servo_enable_in,
  output logic      motion_start_in,
  output logic      forced_stop_in,
  output logic      fwd_travel_limit_in,
  output logic      rev_travel_limit_in
);
  // ----------------------------------------------------------------------
  // Host sequences.
  // ----------------------------------------------------------------------
  // Enable and start stay off while the supplies come up.
  initial begin
    {servo_enable_in, motion_start_in, forced_stop_in, fwd_travel_limit_in, rev_travel_limit_in} = 5'h07;
  end

  // Sets the level lines together just after an edge.
  task automatic set_lines(input logic en, input logic fs, input logic fl, input logic rl);
    @(posedge sys_clk);
    #1;
    servo_enable_in     = en;
    forced_stop_in      = fs;
    fwd_travel_limit_in = fl;
    rev_travel_limit_in = rl;
  endtask

  // Holds start on for the full request time.
  task automatic start_move();
    @(posedge sys_clk);
    #1;
    motion_start_in = 1'b1;
    repeat (START_HOLD) @(posedge sys_clk);
    #1;
    motion_start_in = 1'b0;
  endtask

  // Start off before enable drops, ahead of power removal.
  task automatic shut_down();
    @(posedge sys_clk);
    #1;
    motion_start_in = 1'b0;
    @(posedge sys_clk);
    #1;
    servo_enable_in = 1'b0;
  endtask
endmodule

// ---- tb.sv ----
// Purpose: Self-checking bench for the servo start and stop supervisor.
// Assumes: One millisecond is shortened to ten cycles.
// Notes:   Stop causes run as table rows; moves and power cycles follow.
`timescale 1ns/1ps
module tb;
  import sdc_pkg::*;
  // ----------------------------------------------------------------------
  // Signals and instances.
  // ----------------------------------------------------------------------
  localparam logic [TMR_W-1:0] MS_SIM = 16'h000A;
  typedef struct packed {logic en, fs, al, base, brk, rdy;} sdc_row_t;
  logic                sys_clk, rst_n, main_power_in, link_up_in, abs_detect_en_in, abs_data_valid_in;
  logic                alarm_in, servo_enable_in, motion_start_in, forced_stop_in, fwd_travel_limit_in;
  logic                rev_travel_limit_in, target_valid_in, move_dir_fwd_in, move_done_in, limit_stop_sel_in;
  logic                do_test_in, base_drive_on, dyn_brake_on, servo_lock, droop_clear, limit_decel_stop;
  logic                ready_out, move_start, move_active, move_dir_fwd, torque_lim_en;
  logic                abs_position_lost_alarm, forced_stop_warning, alarm_active;
  logic [STN_W-1:0]    station_no_in;
  logic [DISP_W-1:0]   alarm_code_in, disp_code;
  logic [TQ_DLY_W-1:0] torque_dly_ms_in;
  logic [DO_W-1:0]     do_force_val_in, do_pins;
  int                  failures, tests_run, n_start, n_droop, n_decel, i;
  sdc_row_t            rows [5];

  sdc_supervisor #(.MS_CYCLES(MS_SIM)) dut_u (.*);
  sdc_host_model host_u (.*);

  // ----------------------------------------------------------------------
  // Clock, pulse counters and tasks.
  // ----------------------------------------------------------------------
  // Clock at 10 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Counts one-cycle pulses at the settled falling edge.
  always @(negedge sys_clk) begin
    n_start += int'(move_start === 1'b1);
    n_droop += int'(droop_clear === 1'b1);
    n_decel += int'(limit_decel_stop === 1'b1);
  end

  task automatic chk(input logic [DISP_W-1:0] got, input logic [DISP_W-1:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Holds reset four cycles, checking what shows meanwhile.
  task automatic do_reset();
    rst_n = 1'b0;
    tick(3);
    chk(disp_code, DISP_RESET);
    chk(do_pins, DO_RESET);
    tick(1);
    rst_n = 1'b1;
  endtask

  task automatic final_report();
    $display("Checks run %0d, failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    {failures, tests_run, n_start, n_droop, n_decel} = '0;
    {rst_n, alarm_in, abs_detect_en_in, move_done_in, limit_stop_sel_in, do_test_in, link_up_in} = '0;
    {main_power_in, abs_data_valid_in, target_valid_in, move_dir_fwd_in} = 4'hF;
    station_no_in = 7'h01;
    alarm_code_in = 12'hA10;
    torque_dly_ms_in = TQ_DLY_ZERO;
    do_force_val_in = 4'h0;
    rows = '{6'h35, 6'h10, 6'h22, 6'h3A, 6'h0A};
    do_reset();
    tick(3);
    chk(disp_code, 12'hB01);
    main_power_in = 1'b0;
    do_test_in = 1'b1;
    do_force_val_in = 4'hA;
    tick(2);
    chk(do_pins, 4'hA);
    do_force_val_in = 4'h5;
    tick(2);
    chk(do_pins, 4'h5);
    {do_test_in, main_power_in} = 2'b01;
    // Stop causes, one row each.
    for (i = 0; i < 5; i++) begin
      alarm_in = rows[i].al;
      host_u.set_lines(rows[i].en, rows[i].fs, 1'b1, 1'b1);
      tick(3);
      chk(base_drive_on, rows[i].base);
      chk(dyn_brake_on, rows[i].brk);
      chk(ready_out, rows[i].rdy);
      chk({alarm_active, forced_stop_warning}, {rows[i].al, !rows[i].fs});
      chk(do_pins, {!rows[i].fs, rows[i].al, 1'b0, rows[i].rdy});
    end
    // Torque limit engages about 3 ms after servo on.
    alarm_in = 1'b0;
    torque_dly_ms_in = 8'h03;
    host_u.set_lines(1'b1, 1'b1, 1'b1, 1'b1);
    for (i = 0; i < 80 && torque_lim_en !== 1'b1; i++) tick(1);
    chk(i >= 19 && i <= 42, 1'b1);
    if (i == 80) final_report();
    // Forward move cut short by the forward limit.
    fork
      host_u.start_move();
      begin
        tick(5);
        chk(n_start, 1);
        chk({move_active, move_dir_fwd}, 2'b11);
        host_u.set_lines(1'b1, 1'b1, 1'b0, 1'b1);
        tick(2);
        chk(n_droop, 1);
        chk({move_active, servo_lock}, 2'b01);
      end
    join
    // Reverse move allowed; a second start meanwhile is ignored.
    move_dir_fwd_in = 1'b0;
    host_u.start_move();
    chk({n_start[3:0], move_active}, 5'h05);
    host_u.start_move();
    chk(n_start, 2);
    move_done_in = 1'b1;
    tick(1);
    move_done_in = 1'b0;
    tick(1);
    chk(move_active, 1'b0);
    // Decelerating stop at the forward limit.
    {move_dir_fwd_in, limit_stop_sel_in} = 2'b11;
    host_u.set_lines(1'b1, 1'b1, 1'b1, 1'b1);
    fork
      host_u.start_move();
      begin
        tick(5);
        host_u.set_lines(1'b1, 1'b1, 1'b0, 1'b1);
        tick(2);
        chk({n_start[3:0], n_decel[3:0], move_active}, 9'h062);
      end
    join
    host_u.shut_down();
    tick(3);
    chk({base_drive_on, dyn_brake_on}, 2'b00);
    // Lost absolute data blocks servo on until a power cycle.
    {abs_detect_en_in, abs_data_valid_in} = 2'b10;
    do_reset();
    host_u.set_lines(1'b1, 1'b1, 1'b1, 1'b1);
    tick(4);
    chk({abs_position_lost_alarm, base_drive_on, ready_out}, 3'b100);
    chk(disp_code, ALM_ABS_LOST);
    abs_data_valid_in = 1'b1;
    host_u.shut_down();
    do_reset();
    host_u.set_lines(1'b1, 1'b1, 1'b1, 1'b1);
    tick(4);
    chk({abs_position_lost_alarm, base_drive_on}, 2'b01);
    link_up_in = 1'b1;
    tick(2);
    chk(disp_code, 12'hD01);
    final_report();
  end
endmodule

bind sdc_supervisor sdc_sup_asserts chk_u (.*);
